// *** io_pi_pkg.sv ***
// constants, register map and state type shared by both ends of the io/interrupt link
`default_nettype none
package io_pi_pkg;

  // ----------------------------------------------------------------
  // link geometry
  // ----------------------------------------------------------------
  localparam int NUM_DEV = 9;    // request inputs of the basic interrupt facility
  localparam int WORD_W  = 18;   // accumulator and io bus width
  localparam int SEL_W   = 6;    // device selector code width
  localparam int PC_W    = 13;   // program count width
  localparam int PCH_W   = 2;    // extended program count width

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFF      = 8'h00;
  localparam logic [7:0] ACC_OFF      = 8'h04;
  localparam logic [7:0] STATE_OFF    = 8'h08;
  localparam logic [7:0] SAVE_OFF     = 8'h0c;
  localparam logic [7:0] STATUS_OFF   = 8'h10;
  localparam logic [7:0] INT_STAT_OFF = 8'h14;
  localparam logic [7:0] INT_MASK_OFF = 8'h18;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_EV1_BIT = 6;    // event-1 pulse, code xx01
  localparam int CMD_EV2_BIT = 7;    // event-2 pulse, code xx02
  localparam int CMD_EV4_BIT = 8;    // event-4 pulse, code xx04
  localparam int CMD_CLR_BIT = 9;    // clear accumulator at event 1 (xx12 when with ev2)
  localparam int CMD_ON_BIT  = 10;   // interrupt_on_command
  localparam int CMD_W       = 11;

  // ----------------------------------------------------------------
  // processor state word, also the layout stored in location 0000
  // ----------------------------------------------------------------
  localparam int ST_LINK_BIT = 17;
  localparam int ST_EXT_BIT  = 16;
  localparam int ST_TRAP_BIT = 15;
  localparam int ST_PCH_LSB  = 13;
  localparam int ST_PC_LSB   = 0;

  // ----------------------------------------------------------------
  // status and interrupt fields
  // ----------------------------------------------------------------
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_IEN_BIT  = 1;
  localparam int STS_REQ_BIT  = 2;
  localparam int STS_FLG_LSB  = 3;
  localparam int INT_BRK_BIT  = 0;   // a break was taken
  localparam int INT_SKP_BIT  = 1;   // a skip occurred
  localparam int INT_W        = 2;

  // ----------------------------------------------------------------
  // reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] ACC_RST      = 18'h00000;
  localparam logic [WORD_W-1:0] STATE_RST    = 18'h00000;
  localparam logic [WORD_W-1:0] SAVE_RST     = 18'h00000;
  localparam logic [PC_W-1:0]   BREAK_VECTOR = 13'h0001;   // next fetch after a break
  localparam logic [INT_W-1:0]  INT_RST      = 2'h0;

  // ----------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_EV1  = 6'h02,
    S_EV2  = 6'h04,
    S_EV4  = 6'h08,
    S_FIN  = 6'h10,
    S_BRK  = 6'h20
  } seq_state_t;

endpackage
`default_nettype wire

// *** io_link_if.sv ***
// io link between the processor end and the peripheral device ends
`timescale 1ns/1ps
`default_nettype none
interface io_link_if;
  import io_pi_pkg::*;

  // processor driven: selector code, event pulses, accumulator bus
  logic [SEL_W-1:0]                sel;
  logic                            ev1;
  logic                            ev2;
  logic                            ev4;
  logic [WORD_W-1:0]               out_word;
  // device driven, one slot per device, nets so each device owns its slot
  wire  [NUM_DEV-1:0]              flag_n;
  wire  [NUM_DEV-1:0]              skip_flag;
  wire  [NUM_DEV-1:0][WORD_W-1:0]  in_word;

  modport processor (
    output sel, ev1, ev2, ev4, out_word,
    input  flag_n, skip_flag, in_word
  );

  modport device (
    input  sel, ev1, ev2, ev4, out_word,
    output flag_n, skip_flag, in_word
  );

endinterface
`default_nettype wire

// *** io_pi_device.sv ***
// peripheral device controller end: data and control registers, ready flag
`timescale 1ns/1ps
`default_nettype none
module io_pi_device import io_pi_pkg::*; #(
  parameter logic [SEL_W-1:0] SELECT_CODE  = 6'h34,
  parameter logic [SEL_W-1:0] CONTROL_CODE = 6'h35,
  parameter int               SLOT         = 0
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // link to the processor
  io_link_if.device              link,
  // user side
  output logic [WORD_W-1:0]      data_word,
  output logic [WORD_W-1:0]      control_word,
  output logic                   start,
  output logic                   flag,
  input  wire logic              done,
  input  wire logic              rx_load,
  input  wire logic [WORD_W-1:0] rx_word
);

  logic              sel_data;
  logic              sel_ctrl;
  logic [WORD_W-1:0] rx_buf;

  // ----------------------------------------------------------------
  // channel decode
  // ----------------------------------------------------------------
  assign sel_data = (link.sel == SELECT_CODE);
  assign sel_ctrl = (link.sel == CONTROL_CODE);

  // word capture from the accumulator bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_word    <= ACC_RST;
      control_word <= ACC_RST;
    end else begin
      if (link.ev2 && sel_data) begin
        data_word <= link.out_word;
      end
      if (link.ev2 && sel_ctrl) begin
        control_word <= link.out_word;
      end
    end
  end

  // start pulse to the mechanism, one cycle after the event-4 pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start <= 1'b0;
    end else begin
      start <= link.ev4 && sel_data;
    end
  end

  // ready flag: completion wins over the clearing start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (done || rx_load) begin
      flag <= 1'b1;
    end else if (link.ev4 && sel_data) begin
      flag <= 1'b0;
    end
  end

  // input buffer filled by the user side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf <= ACC_RST;
    end else if (rx_load) begin
      rx_buf <= rx_word;
    end
  end

  // ----------------------------------------------------------------
  // request, skip and input gates
  // ----------------------------------------------------------------
  assign link.flag_n[SLOT]    = ~flag;
  assign link.skip_flag[SLOT] = flag && sel_data;
  // buffer only gated while selected, so several devices can share the or
  assign link.in_word[SLOT]   = (link.ev2 && sel_data) ? rx_buf : ACC_RST;

endmodule
`default_nettype wire

// *** io_pi_processor.sv ***
// processor end: io command sequencer, skip, program interrupt and apb registers
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - event-2 pulse moves accumulator into device register
// - device starts operating on event-4 pulse
// - control word sets device control mode
// - three commands: skip test, transfer, start
// - enabled interrupt: ready flag forces break
// - nine request inputs, count expandable
// - request flag is active-low level
// - request flag also feeds skip facility
// - any flag breaks if enabled, none active
// - break stores link, extend, trap, counts
// - after break fetch from location one
// - break only at end of instruction
// - software polls each device with event-1
// - clear plus event-2 loads device buffer
// - start pulse clears device ready flag
// - skip when selected flag and event-1
module io_pi_processor import io_pi_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt to software
  output logic             irq,
  // link to the devices
  io_link_if.processor     link
);

  seq_state_t                     state;
  logic [CMD_W-1:0]               cmd;
  logic [WORD_W-1:0]              acc;
  logic [WORD_W-1:0]              cpu_word;
  logic [WORD_W-1:0]              save_word;
  logic                           ien;
  logic                           skip_hit;
  logic [INT_W-1:0]               int_stat;
  logic [INT_W-1:0]               int_mask;
  logic [NUM_DEV-1:0]             req_lines;
  logic                           req;
  logic                           skip_now;
  wire  [NUM_DEV:0][WORD_W-1:0]   in_chain;
  logic [PC_W-1:0]                next_pc;
  logic                           wr;
  logic                           rd_setup;
  logic [7:0]                     addr;
  logic                           mapped;
  logic                           idle;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign addr     = paddr[7:0];
  assign mapped   = (paddr[31:8] == 24'h000000) &&
                    (addr == CMD_OFF || addr == ACC_OFF || addr == STATE_OFF ||
                     addr == SAVE_OFF || addr == STATUS_OFF ||
                     addr == INT_STAT_OFF || addr == INT_MASK_OFF);
  assign wr       = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;                               // zero wait states
  assign pslverr  = psel && penable && !mapped;
  assign idle     = (state == S_IDLE);

  // ----------------------------------------------------------------
  // request and skip gathering
  // ----------------------------------------------------------------
  assign req_lines = ~link.flag_n;
  assign req       = |req_lines;
  assign skip_now  = (state == S_EV1) && cmd[CMD_EV1_BIT] && (|link.skip_flag);

  // information collector: inclusive or of every device slot
  assign in_chain[0] = ACC_RST;
  for (genvar i = 0; i < NUM_DEV; i++) begin : g_collect
    assign in_chain[i+1] = in_chain[i] | link.in_word[i];
  end

  // next instruction address, one further on a skip
  assign next_pc = cpu_word[ST_PC_LSB +: PC_W] + (skip_hit ? PC_W'(2) : PC_W'(1));

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  assign link.sel      = cmd[CMD_SEL_LSB +: SEL_W];
  assign link.ev1      = (state == S_EV1) && cmd[CMD_EV1_BIT];
  assign link.ev2      = (state == S_EV2) && cmd[CMD_EV2_BIT];
  assign link.ev4      = (state == S_EV4) && cmd[CMD_EV4_BIT];
  assign link.out_word = acc;

  // instruction sequencer; a new command is refused while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (wr && addr == CMD_OFF) begin
            state <= S_EV1;
          end
        end
        S_EV1: state <= S_EV2;
        S_EV2: state <= S_EV4;
        S_EV4: state <= S_FIN;
        S_FIN: begin
          // checked only here, never mid-instruction
          if (ien && req) begin
            state <= S_BRK;
          end else begin
            state <= S_IDLE;
          end
        end
        S_BRK: state <= S_IDLE;
      endcase
    end
  end

  // command latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (idle && wr && addr == CMD_OFF) begin
      cmd <= pwdata[CMD_W-1:0];
    end
  end

  // skip memory for the running instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_hit <= 1'b0;
    end else if (state == S_IDLE) begin
      skip_hit <= 1'b0;
    end else if (skip_now) begin
      skip_hit <= 1'b1;
    end
  end

  // accumulator: clear at event 1, or-in at event 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RST;
    end else if (idle && wr && addr == ACC_OFF) begin
      acc <= pwdata[WORD_W-1:0];
    end else if (state == S_EV1 && cmd[CMD_CLR_BIT]) begin
      acc <= ACC_RST;
    end else if (link.ev2) begin
      acc <= acc | in_chain[NUM_DEV];
    end
  end

  // link, extend, trap, extended count and program count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_word <= STATE_RST;
    end else if (idle && wr && addr == STATE_OFF) begin
      cpu_word <= pwdata[WORD_W-1:0];
    end else if (state == S_FIN) begin
      cpu_word[ST_PC_LSB +: PC_W] <= next_pc;
    end else if (state == S_BRK) begin
      cpu_word[ST_PC_LSB +: PC_W] <= BREAK_VECTOR;
    end
  end

  // location 0000: state saved on break entry, pc already advanced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_word <= SAVE_RST;
    end else if (state == S_BRK) begin
      save_word <= cpu_word;
    end
  end

  // interrupt enable; the break shuts it until the next interrupt-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien <= 1'b0;
    end else if (state == S_BRK) begin
      ien <= 1'b0;
    end else if (state == S_FIN && cmd[CMD_ON_BIT]) begin
      ien <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // software interrupt: sticky events, set beats write-one-clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= INT_RST;
    end else begin
      for (int b = 0; b < INT_W; b++) begin
        if ((b == INT_BRK_BIT && state == S_BRK) || (b == INT_SKP_BIT && skip_now)) begin
          int_stat[b] <= 1'b1;
        end else if (wr && addr == INT_STAT_OFF && pwdata[b]) begin
          int_stat[b] <= 1'b0;
        end
      end
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= INT_RST;
    end else if (wr && addr == INT_MASK_OFF) begin
      int_mask <= pwdata[INT_W-1:0];
    end
  end

  assign irq = |(int_stat & int_mask);

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= 32'h00000000;
      if (paddr[31:8] == 24'h000000) begin
        case (addr)
          CMD_OFF:      prdata[CMD_W-1:0]  <= cmd;
          ACC_OFF:      prdata[WORD_W-1:0] <= acc;
          STATE_OFF:    prdata[WORD_W-1:0] <= cpu_word;
          SAVE_OFF:     prdata[WORD_W-1:0] <= save_word;
          STATUS_OFF: begin
            prdata[STS_BUSY_BIT] <= !idle;
            prdata[STS_IEN_BIT]  <= ien;
            prdata[STS_REQ_BIT]  <= req;
            prdata[STS_FLG_LSB +: NUM_DEV] <= req_lines;
          end
          INT_STAT_OFF: prdata[INT_W-1:0]  <= int_stat;
          INT_MASK_OFF: prdata[INT_W-1:0]  <= int_mask;
          default:      prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** io_link_sva.sv ***
// assertion checker watching the io link between processor and devices
`timescale 1ns/1ps
`default_nettype none
module io_link_sva import io_pi_pkg::*; #(
  parameter logic [SEL_W-1:0] SEL_A = 6'h34,
  parameter logic [SEL_W-1:0] SEL_B = 6'h44
) (
  // clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  // processor driven
  input wire logic [SEL_W-1:0]               sel,
  input wire logic                           ev1,
  input wire logic                           ev2,
  input wire logic                           ev4,
  input wire logic [WORD_W-1:0]              out_word,
  // device driven
  input wire logic [NUM_DEV-1:0]             flag_n,
  input wire logic [NUM_DEV-1:0]             skip_flag,
  input wire logic [NUM_DEV-1:0][WORD_W-1:0] in_word
);
  // ----------------------------------------------------------------
  // one clock domain, so clocking and disable are set once
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ev_single: assert property (ev2 |=> !ev2)
    else $error("transfer pulse longer than one cycle");
  a_ev_exclusive: assert property ($onehot0({ev1, ev2, ev4}))
    else $error("two event pulses in one cycle");
  a_ev_spacing: assert property (ev1 |=> (!ev1 && !ev4) ##1 (!ev1 && !ev2))
    else $error("event pulses out of order");
  a_sel_held: assert property ((ev2 || ev4) |-> $stable(sel))
    else $error("selector changed inside an instruction");
  a_skip_needs_flag: assert property ((skip_flag & flag_n) == '0)
    else $error("skip offered without a request flag");
  a_skip_qualified: assert property ((!skip_flag[0] || sel == SEL_A) &&
    (!skip_flag[1] || sel == SEL_B)) else $error("skip from an unselected device");
  a_in_word_gated: assert property (in_word[1] != '0 |-> ev2 && sel == SEL_B)
    else $error("input word driven outside its transfer");
  a_flag_cleared: assert property (ev4 && sel == SEL_A |=> flag_n[0])
    else $error("start pulse left the ready flag set");
  a_flag_rise_cause: assert property ($rose(flag_n[1]) |-> $past(ev4) &&
    $past(sel) == SEL_B) else $error("request dropped without a start pulse");

  // main scenarios reached
  c_word_out: cover property (ev2 && sel == SEL_A && out_word != '0);
  c_skip: cover property (ev1 && skip_flag[0]);
  c_word_in: cover property (ev2 && in_word[1] != '0);
endmodule
`default_nettype wire

// *** tb_io_output_and_program_interrupt.sv ***
// self-checking testbench for both ends of the io output and interrupt link
`timescale 1ns/1ps
`default_nettype none
module tb_io_output_and_program_interrupt import io_pi_pkg::*;;
  localparam logic [SEL_W-1:0] SEL_A = 6'h34;
  localparam logic [SEL_W-1:0] SEL_B = 6'h44;
  localparam logic [4:0]       EV1 = 5'h01, EV2 = 5'h02, EV4 = 5'h04, CLR = 5'h08, INT_ON = 5'h10;
  // clock, reset and apb
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0]       paddr, pwdata, prdata, rd;
  // device user sides
  logic [WORD_W-1:0] data_a, ctrl_a, data_b, ctrl_b, rx_word_a, rx_word_b;
  logic              start_a, start_b, flag_a, flag_b, done_a, done_b, rx_load_a, rx_load_b;
  logic              ext_req_n;
  int                n_fail = 0, num_checks = 0, starts_a = 0, starts_b = 0, s;

  // ----------------------------------------------------------------
  // link, ends and checker
  // ----------------------------------------------------------------
  io_link_if link_bus ();
  // slot 8 is a raw request line; the slots between stay idle
  assign link_bus.flag_n[8:2]    = {ext_req_n, 6'h3f};
  assign link_bus.skip_flag[8:2] = 7'h00;
  assign link_bus.in_word[8:2]   = '0;

  io_pi_processor io_pi_processor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link_bus));
  io_pi_device #(.SELECT_CODE(SEL_A), .CONTROL_CODE(6'h35), .SLOT(0)) io_pi_device_i (
    .pclk(pclk), .presetn(presetn), .link(link_bus), .data_word(data_a), .control_word(ctrl_a),
    .start(start_a), .flag(flag_a), .done(done_a), .rx_load(rx_load_a), .rx_word(rx_word_a));
  io_pi_device #(.SELECT_CODE(SEL_B), .CONTROL_CODE(6'h45), .SLOT(1)) io_pi_device_b_i (
    .pclk(pclk), .presetn(presetn), .link(link_bus), .data_word(data_b), .control_word(ctrl_b),
    .start(start_b), .flag(flag_b), .done(done_b), .rx_load(rx_load_b), .rx_word(rx_word_b));
  io_link_sva #(.SEL_A(SEL_A), .SEL_B(SEL_B)) io_link_sva_i (.pclk(pclk), .presetn(presetn),
    .sel(link_bus.sel), .ev1(link_bus.ev1), .ev2(link_bus.ev2), .ev4(link_bus.ev4),
    .out_word(link_bus.out_word), .flag_n(link_bus.flag_n), .skip_flag(link_bus.skip_flag),
    .in_word(link_bus.in_word));

  // clock and start pulse counters
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (start_a === 1'b1) starts_a++;
    if (start_b === 1'b1) starts_b++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; an idle cycle follows so strobes are never reassigned at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk(32'(pslverr), 32'(err), "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp, what);
  endtask

  // issue one instruction and poll until the sequencer is idle again
  task automatic run(input logic [SEL_W-1:0] code, input logic [4:0] bits);
    apb(1'b1, CMD_OFF, {21'h0, bits, code}, 1'b0);
    rd = 32'h1;
    while (rd[STS_BUSY_BIT] !== 1'b0) apb(1'b0, STATUS_OFF, 32'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(ACC_OFF, 32'h0, "acc after reset");
    rd_chk(SAVE_OFF, 32'h0, "save after reset");
    rd_chk(STATUS_OFF, 32'h0, "status after reset");
    rd_chk(INT_STAT_OFF, 32'h0, "events after reset");
    apb(1'b0, 8'h1c, 32'h0, 1'b1);
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, SAVE_OFF, 32'h3ffff, 1'b0);
    rd_chk(SAVE_OFF, 32'h0, "save is read-only");
    $display("test reset done");
  endtask

  task automatic t_output;
    done_a <= 1'b1;
    @(posedge pclk);
    done_a <= 1'b0;
    apb(1'b1, ACC_OFF, 32'h2a5a5, 1'b0);
    s = starts_a;
    run(SEL_A, EV2 | EV4);
    chk(32'(data_a), 32'h2a5a5, "data word captured");
    chk(32'(starts_a - s), 32'h1, "one start pulse");
    chk(32'(flag_a), 32'h0, "flag cleared by start");
    apb(1'b1, ACC_OFF, 32'h15a5a, 1'b0);
    run(6'h35, EV2);
    chk(32'(ctrl_a), 32'h15a5a, "control word captured");
    chk(32'(data_a), 32'h2a5a5, "data word untouched");
    $display("test output done");
  endtask

  task automatic t_skip;
    done_a <= 1'b1;
    @(posedge pclk);
    done_a <= 1'b0;
    apb(1'b1, STATE_OFF, 32'h00100, 1'b0);
    rd_chk(STATUS_OFF, 32'h0000000c, "request and slot flag");
    run(SEL_B, EV1);
    rd_chk(STATE_OFF, 32'h00101, "no skip on idle device");
    run(SEL_A, EV1);
    rd_chk(STATE_OFF, 32'h00103, "skip on ready device");
    rd_chk(INT_STAT_OFF, 32'h2, "skip event noted");
    apb(1'b1, INT_STAT_OFF, 32'h2, 1'b0);
    rd_chk(INT_STAT_OFF, 32'h0, "skip event cleared");
    run(SEL_A, EV4);
    rd_chk(STATUS_OFF, 32'h0, "no request after start");
    $display("test skip done");
  endtask

  task automatic t_input;
    rx_word_b <= 18'h0f0f0;
    rx_load_b <= 1'b1;
    @(posedge pclk);
    rx_load_b <= 1'b0;
    apb(1'b1, ACC_OFF, 32'h30001, 1'b0);
    run(SEL_B, EV2);
    rd_chk(ACC_OFF, 32'h3f0f1, "input or-ed into acc");
    chk(32'(data_b), 32'h30001, "input device captured acc");
    s = starts_b;
    run(SEL_B, CLR | EV2 | EV4);
    rd_chk(ACC_OFF, 32'h0f0f0, "clear then input");
    chk(32'(flag_b), 32'h0, "input flag cleared");
    chk(32'(starts_b - s), 32'h1, "input device started");
    run(6'h45, EV2);
    chk(32'(ctrl_b), 32'h0f0f0, "input control word captured");
    $display("test input done");
  endtask

  task automatic t_interrupt;
    apb(1'b1, INT_MASK_OFF, 32'h1, 1'b0);
    apb(1'b1, STATE_OFF, 32'h2c402, 1'b0);
    ext_req_n <= 1'b0;
    run(6'h00, INT_ON);
    rd_chk(INT_STAT_OFF, 32'h0, "no break while disabled");
    rd_chk(STATUS_OFF, 32'h00000806, "slot 8 request seen");
    run(6'h00, 5'h00);
    rd_chk(SAVE_OFF, 32'h2c404, "state saved at break");
    apb(1'b0, STATE_OFF, 32'h0, 1'b0);
    chk(32'(rd[12:0]), 32'(BREAK_VECTOR), "fetch from location one");
    rd_chk(INT_STAT_OFF, 32'h1, "break noted");
    chk(32'(irq), 32'h1, "irq raised");
    rd_chk(STATUS_OFF, 32'h00000804, "break disables interrupts");
    apb(1'b1, INT_MASK_OFF, 32'h0, 1'b0);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, INT_MASK_OFF, 32'h1, 1'b0);
    apb(1'b1, INT_STAT_OFF, 32'h1, 1'b0);
    chk(32'(irq), 32'h0, "irq cleared");
    run(6'h00, 5'h00);
    rd_chk(INT_STAT_OFF, 32'h0, "no break until re-enabled");
    run(6'h00, INT_ON);
    run(6'h00, 5'h00);
    rd_chk(INT_STAT_OFF, 32'h1, "held request breaks again");
    ext_req_n <= 1'b1;
    apb(1'b1, INT_STAT_OFF, 32'h1, 1'b0);
    rd_chk(STATUS_OFF, 32'h0, "request released");
    $display("test interrupt done");
  endtask

  // ----------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {done_a, done_b, rx_load_a, rx_load_b, rx_word_a, rx_word_b} = '0;
    ext_req_n = 1'b1;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_output;
    t_skip;
    t_input;
    t_interrupt;
    report_and_stop;
  end

  // the tests need a few hundred cycles; this is generous
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
`default_nettype wire
